/* shared/voice_frame_regs.svh */
// Named constants of the fixed-format serial voice port.
// Assumes inclusion by bare name from the package and the serial master core file.
`ifndef VOICE_FRAME_REGS_SVH
`define VOICE_FRAME_REGS_SVH

// Fixed link format
`define FRAME_RATE_HZ     8000
`define BIT_RATE_HZ       768000
`define SLOTS_PER_FRAME   6
`define SLOT_BITS         16
`define AUDIO_SLOT        0

// Frame sync shape and timing, in ns
`define SYNC_HIGH_NS      32000
`define BIT_PERIOD_NS     1302
`define SYNC_LEAD_NS      154

// Clock of the link-side logic, Hz
`define LINK_CLK_HZ       12500000

// Flip-flops on every pin input
`define IN_SYNC_STAGES    2

// Word sent when no sample is waiting
`define IDLE_FILL         16'h0000

// Depth of the sample buffers
`define SAMPLE_BUF_DEPTH  2

`endif

/* shared/voice_frame_pkg.sv */
// Types shared by the serial voice port, its monitor and its bench.
// Assumes the constants header is on the include path.
`include "voice_frame_regs.svh"

package voice_frame_pkg;

    typedef logic [`SLOT_BITS-1:0] sample_t;

    // Bit clock phase of the link-side sequencer, Gray along the path
    typedef enum logic [1:0] {
        LK_START = 2'b00,
        LK_HIGH  = 2'b01,
        LK_LOW   = 2'b11
    } link_phase_t;

endpackage

/* core/sample_buffer.sv */
// Small FIFO for sample words, valid/ready on both sides.
// Assumes one clock; ready and valid flags are registered.
`timescale 1ns/1ps

module sample_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_arst_n,
    // Filling side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Draining side
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;
    logic [CW-1:0]    count_d;
    logic             not_full_q;
    logic             not_empty_q;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == LAST_SLOT) ? '0 : p + AW'(1);
    endfunction

    assign push = i_in_valid & not_full_q;
    assign pop  = not_empty_q & i_out_ready;

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + CW'(1);
        end else if (pop && !push) begin
            count_d = count_q - CW'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            count_q     <= '0;
            not_full_q  <= 1'b1;
            not_empty_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= next_ptr(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= next_ptr(rd_ptr_q);
            end
            count_q     <= count_d;
            not_full_q  <= (count_d != FULL_COUNT);
            not_empty_q <= (count_d != '0);
        end
    end

    assign o_in_ready  = not_full_q;
    assign o_out_valid = not_empty_q;
    assign o_out_data  = mem[rd_ptr_q];

endmodule // sample_buffer

/* core/voice_frame_serial_master.sv */
// Master end of a fixed four-wire serial voice port, one sample per frame.
// Assumes a free-running link clock beside the system clock, and that the
// peripheral drives data in from the bit clock that this block sources.
`timescale 1ns/1ps
`include "voice_frame_regs.svh"

module voice_frame_serial_master #(
    parameter int LINK_CLK_HZ = `LINK_CLK_HZ,
    parameter int BUF_DEPTH   = `SAMPLE_BUF_DEPTH
) (
    // System clock and reset
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_arst_n,
    // Link clock
    input  wire logic                     i_clk_link,
    // Samples to send
    input  wire logic                     i_tx_valid,
    input  wire voice_frame_pkg::sample_t i_tx_sample,
    output logic                          o_tx_ready,
    // Samples received
    output logic                          o_rx_valid,
    output voice_frame_pkg::sample_t      o_rx_sample,
    input  wire logic                     i_rx_ready,
    // Status pulses
    output logic                          o_frame_start,
    output logic                          o_tx_underrun,
    output logic                          o_rx_overrun,
    // Serial pins
    output logic                          o_frame_sync,
    output logic                          o_bit_clk,
    output logic                          o_data_out,
    input  wire logic                     i_data_in
);

    import voice_frame_pkg::*;

    localparam int BITS_PER_FRAME = `BIT_RATE_HZ / `FRAME_RATE_HZ;
    localparam int HALF_CYCLES    = LINK_CLK_HZ / (2 * `BIT_RATE_HZ);
    localparam int SYNC_HIGH_BITS = `SYNC_HIGH_NS / `BIT_PERIOD_NS;
    localparam int LEAD_RAW       = (`SYNC_LEAD_NS * (LINK_CLK_HZ / 1000)) / 1000000;
    localparam int LEAD_CYCLES    = (LEAD_RAW < 1) ? 1 : LEAD_RAW;
    localparam int SLOT_FIRST     = `AUDIO_SLOT * `SLOT_BITS;
    localparam int SLOT_LAST      = SLOT_FIRST + `SLOT_BITS - 1;
    localparam sample_t IDLE_WORD = `IDLE_FILL;

    localparam logic [7:0] HALF_LAST  = 8'(HALF_CYCLES - 1);
    localparam logic [7:0] SYNC_POINT = 8'(HALF_CYCLES - 1 - LEAD_CYCLES);
    localparam logic [7:0] SAMPLE_PT  = 8'(`IN_SYNC_STAGES);
    localparam logic [6:0] FRAME_LAST = 7'(BITS_PER_FRAME - 1);
    localparam logic [6:0] SYNC_BITS  = 7'(SYNC_HIGH_BITS);
    localparam logic [6:0] SLOT_LO    = 7'(SLOT_FIRST);
    localparam logic [6:0] SLOT_HI    = 7'(SLOT_LAST);

    localparam int EV_RX    = 0;
    localparam int EV_UNDER = 1;
    localparam int EV_FRAME = 2;
    localparam int EV_COUNT = 3;

    // Bit index after the one given, wrapping at the frame end
    function automatic logic [6:0] next_bit(input logic [6:0] b);
        next_bit = (b == FRAME_LAST) ? 7'h00 : b + 7'h01;
    endfunction

    // True for bit positions inside the audio slot
    function automatic logic in_audio_slot(input logic [6:0] b);
        in_audio_slot = (b >= SLOT_LO) && (b <= SLOT_HI);
    endfunction

    // ------------------------------------------------------------------
    // Link-domain reset: asserted at once, released on the link clock
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;
    logic link_rst_n;

    always_ff @(posedge i_clk_link or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign link_rst_n = rst_sync_q;

    // ------------------------------------------------------------------
    // System side: transmit buffer and word handshake towards the link
    // ------------------------------------------------------------------
    logic    tx_buf_valid;
    sample_t tx_buf_data;
    logic    tx_idle;
    logic    tx_pop;
    sample_t tx_hold_q;
    logic    req_q;
    logic    ack_meta_q;
    logic    ack_sync_q;
    logic    req_seen_q;

    sample_buffer #(
        .WIDTH ($bits(sample_t)),
        .DEPTH (BUF_DEPTH)
    ) u_tx_buf (
        .i_clk       (i_clk_sys),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (i_tx_valid),
        .i_in_data   (i_tx_sample),
        .o_in_ready  (o_tx_ready),
        .o_out_valid (tx_buf_valid),
        .o_out_data  (tx_buf_data),
        .i_out_ready (tx_idle)
    );

    // A new word goes out only once the link has taken the last one
    assign tx_idle = (req_q == ack_sync_q);
    assign tx_pop  = tx_buf_valid & tx_idle;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_meta_q <= 1'b0;
            ack_sync_q <= 1'b0;
        end else begin
            ack_meta_q <= req_seen_q;
            ack_sync_q <= ack_meta_q;
        end
    end

    // Hold stays still while the request is outstanding
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_hold_q <= `IDLE_FILL;
            req_q     <= 1'b0;
        end else if (tx_pop) begin
            tx_hold_q <= tx_buf_data;
            req_q     <= ~req_q;
        end
    end

    // ------------------------------------------------------------------
    // Link side: request synchroniser and one-word staging register
    // ------------------------------------------------------------------
    logic    req_meta_q;
    logic    req_sync_q;
    sample_t next_word_q;
    logic    next_have_q;
    logic    take_word;
    logic    frame_begin;

    always_ff @(posedge i_clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            req_meta_q <= 1'b0;
            req_sync_q <= 1'b0;
        end else begin
            req_meta_q <= req_q;
            req_sync_q <= req_meta_q;
        end
    end

    assign take_word = (req_sync_q != req_seen_q) && !next_have_q;

    always_ff @(posedge i_clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            next_word_q <= `IDLE_FILL;
            next_have_q <= 1'b0;
            req_seen_q  <= 1'b0;
        end else begin
            if (take_word) begin
                next_word_q <= tx_hold_q;
                next_have_q <= 1'b1;
                req_seen_q  <= req_sync_q;
            end else if (frame_begin) begin
                next_have_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Link side: bit clock sequencer
    // ------------------------------------------------------------------
    link_phase_t phase_q;
    logic [7:0]  half_cnt_q;
    logic [6:0]  bit_cnt_q;
    logic [6:0]  bit_new;
    logic        half_wrap;
    logic        rise;
    logic        fall;
    logic        sync_pt;
    logic        sample_pt;

    assign half_wrap   = (half_cnt_q == HALF_LAST);
    assign rise        = half_wrap && (phase_q != LK_HIGH);
    assign fall        = half_wrap && (phase_q == LK_HIGH);
    assign bit_new     = next_bit(bit_cnt_q);
    assign frame_begin = rise && (bit_new == 7'h00);
    // Sync moves a little ahead of the rising edge that opens the bit
    assign sync_pt     = (phase_q != LK_HIGH) && (half_cnt_q == SYNC_POINT);
    // Data in is read once it has cleared the pin synchroniser
    assign sample_pt   = (phase_q == LK_LOW) && (half_cnt_q == SAMPLE_PT);

    // Fixed division from the link clock, no other rate selectable
    always_ff @(posedge i_clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            half_cnt_q <= 8'h00;
            phase_q    <= LK_START;
        end else if (half_wrap) begin
            half_cnt_q <= 8'h00;
            case (phase_q)
                LK_START: phase_q <= LK_HIGH;
                LK_HIGH:  phase_q <= LK_LOW;
                LK_LOW:   phase_q <= LK_HIGH;
                default:  phase_q <= LK_START;
            endcase
        end else begin
            half_cnt_q <= half_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge i_clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            o_bit_clk <= 1'b0;
        end else if (rise) begin
            o_bit_clk <= 1'b1;
        end else if (fall) begin
            o_bit_clk <= 1'b0;
        end
    end

    // First rising edge after reset opens bit 0 of a frame
    always_ff @(posedge i_clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_q <= FRAME_LAST;
        end else if (rise) begin
            bit_cnt_q <= bit_new;
        end
    end

    // Long sync: high for the first bits of every 96-bit frame
    always_ff @(posedge i_clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            o_frame_sync <= 1'b0;
        end else if (sync_pt) begin
            o_frame_sync <= (bit_new < SYNC_BITS);
        end
    end

    // ------------------------------------------------------------------
    // Link side: transmit shifter, launched on the rising edge
    // ------------------------------------------------------------------
    sample_t tx_shift_q;
    logic    under_tog_q;

    // Unused slots carry the idle fill level on a push-pull driver
    always_ff @(posedge i_clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_shift_q  <= `IDLE_FILL;
            o_data_out  <= 1'b0;
            under_tog_q <= 1'b0;
        end else if (rise) begin
            if (bit_new == SLOT_LO) begin
                if (next_have_q) begin
                    tx_shift_q <= next_word_q;
                    o_data_out <= next_word_q[`SLOT_BITS-1];
                end else begin
                    tx_shift_q  <= `IDLE_FILL;
                    o_data_out  <= IDLE_WORD[`SLOT_BITS-1];
                    under_tog_q <= ~under_tog_q;
                end
            end else if (in_audio_slot(bit_new)) begin
                o_data_out <= tx_shift_q[`SLOT_BITS-2];
                tx_shift_q <= tx_shift_q << 1;
            end else begin
                o_data_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Link side: receive path, read after the falling edge
    // ------------------------------------------------------------------
    logic    din_meta_q;
    logic    din_sync_q;
    sample_t rx_shift_q;
    sample_t rx_word_q;
    logic    rx_tog_q;
    logic    frame_tog_q;

    // The pin idles high when floated, so an unused input reads all ones
    always_ff @(posedge i_clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            din_meta_q <= 1'b1;
            din_sync_q <= 1'b1;
        end else begin
            din_meta_q <= i_data_in;
            din_sync_q <= din_meta_q;
        end
    end

    always_ff @(posedge i_clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_shift_q <= '0;
            rx_word_q  <= '0;
            rx_tog_q   <= 1'b0;
        end else if (sample_pt && in_audio_slot(bit_cnt_q)) begin
            rx_shift_q <= {rx_shift_q[`SLOT_BITS-2:0], din_sync_q};
            if (bit_cnt_q == SLOT_HI) begin
                rx_word_q <= {rx_shift_q[`SLOT_BITS-2:0], din_sync_q};
                rx_tog_q  <= ~rx_tog_q;
            end
        end
    end

    always_ff @(posedge i_clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            frame_tog_q <= 1'b0;
        end else if (frame_begin) begin
            frame_tog_q <= ~frame_tog_q;
        end
    end

    // ------------------------------------------------------------------
    // Link events into the system domain, one toggle synchroniser each
    // ------------------------------------------------------------------
    logic [EV_COUNT-1:0] ev_tog;
    logic [EV_COUNT-1:0] ev_meta_q;
    logic [EV_COUNT-1:0] ev_sync_q;
    logic [EV_COUNT-1:0] ev_last_q;
    logic [EV_COUNT-1:0] ev_pulse;

    assign ev_tog[EV_RX]    = rx_tog_q;
    assign ev_tog[EV_UNDER] = under_tog_q;
    assign ev_tog[EV_FRAME] = frame_tog_q;

    genvar gi;
    generate
        for (gi = 0; gi < EV_COUNT; gi++) begin : g_ev_sync
            always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    ev_meta_q[gi] <= 1'b0;
                    ev_sync_q[gi] <= 1'b0;
                    ev_last_q[gi] <= 1'b0;
                end else begin
                    ev_meta_q[gi] <= ev_tog[gi];
                    ev_sync_q[gi] <= ev_meta_q[gi];
                    ev_last_q[gi] <= ev_sync_q[gi];
                end
            end
            assign ev_pulse[gi] = ev_sync_q[gi] ^ ev_last_q[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // System side: receive buffer and output stage
    // ------------------------------------------------------------------
    logic    rx_buf_ready;
    logic    rx_buf_valid;
    sample_t rx_buf_data;
    logic    rx_take;

    // The word register is stable for most of a frame after its toggle
    sample_buffer #(
        .WIDTH ($bits(sample_t)),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .i_clk       (i_clk_sys),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (ev_pulse[EV_RX]),
        .i_in_data   (rx_word_q),
        .o_in_ready  (rx_buf_ready),
        .o_out_valid (rx_buf_valid),
        .o_out_data  (rx_buf_data),
        .i_out_ready (rx_take)
    );

    assign rx_take = rx_buf_valid && (!o_rx_valid || i_rx_ready);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rx_valid  <= 1'b0;
            o_rx_sample <= '0;
        end else if (rx_take) begin
            o_rx_valid  <= 1'b1;
            o_rx_sample <= rx_buf_data;
        end else if (i_rx_ready) begin
            o_rx_valid  <= 1'b0;
        end
    end

    // A word that meets a full buffer is dropped and reported
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_frame_start <= 1'b0;
            o_tx_underrun <= 1'b0;
            o_rx_overrun  <= 1'b0;
        end else begin
            o_frame_start <= ev_pulse[EV_FRAME];
            o_tx_underrun <= ev_pulse[EV_UNDER];
            o_rx_overrun  <= ev_pulse[EV_RX] & ~rx_buf_ready;
        end
    end

endmodule // voice_frame_serial_master

/* test/voice_frame_monitor.sv */
// Checker of the voice port pins and streams.
// Assumes 8 link cycles per half bit, 1536 per frame.
`timescale 1ns/1ps

module voice_frame_monitor (
    // Clocks and reset
    input wire logic                     i_clk_sys,
    input wire logic                     i_arst_n,
    input wire logic                     i_clk_link,
    // Streams
    input wire logic                     o_tx_ready,
    input wire logic                     o_rx_valid,
    input wire voice_frame_pkg::sample_t o_rx_sample,
    input wire logic                     i_rx_ready,
    input wire logic                     o_tx_underrun,
    input wire logic                     o_rx_overrun,
    // Pins
    input wire logic                     o_frame_sync,
    input wire logic                     o_bit_clk,
    input wire logic                     o_data_out
);
    import voice_frame_pkg::*;

    // Link cycles since sync rose, 0 before the first frame
    logic [10:0] frm_q;

    always_ff @(posedge i_clk_link or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frm_q <= 11'h000;
        end else if ($rose(o_frame_sync)) begin
            frm_q <= 11'h001;
        end else if (frm_q != 11'h000) begin
            frm_q <= frm_q + 11'h001;
        end
    end

    property p_bclk_high; @(posedge i_clk_link) disable iff (!i_arst_n)
        $rose(o_bit_clk) |-> o_bit_clk [*8] ##1 !o_bit_clk; endproperty
    a_bclk_high: assert property (p_bclk_high) else $error("clock high time");
    property p_bclk_low; @(posedge i_clk_link) disable iff (!i_arst_n)
        $fell(o_bit_clk) |-> !o_bit_clk [*8] ##1 o_bit_clk; endproperty
    a_bclk_low: assert property (p_bclk_low) else $error("clock low time");
    property p_sync_lead; @(posedge i_clk_link) disable iff (!i_arst_n)
        $rose(o_frame_sync) |=> $rose(o_bit_clk); endproperty
    a_sync_lead: assert property (p_sync_lead) else $error("sync lead");
    property p_sync_high; @(posedge i_clk_link) disable iff (!i_arst_n)
        $fell(o_frame_sync) |-> frm_q == 11'h180; endproperty
    a_sync_high: assert property (p_sync_high) else $error("sync high span");
    property p_frame_period; @(posedge i_clk_link) disable iff (!i_arst_n)
        $rose(o_frame_sync) && frm_q != 11'h000 |-> frm_q == 11'h600; endproperty
    a_frame_period: assert property (p_frame_period) else $error("frame period");
    property p_idle_slots; @(posedge i_clk_link) disable iff (!i_arst_n)
        frm_q > 11'h101 |-> !o_data_out; endproperty
    a_idle_slots: assert property (p_idle_slots) else $error("data in idle slot");
    property p_launch_edge; @(posedge i_clk_link) disable iff (!i_arst_n)
        $changed(o_data_out) |-> $rose(o_bit_clk); endproperty
    a_launch_edge: assert property (p_launch_edge) else $error("data off edge");
    property p_rx_hold; @(posedge i_clk_sys) disable iff (!i_arst_n)
        o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_sample); endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx word dropped");

    c_overrun: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) o_rx_overrun);
    c_tx_full: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) !o_tx_ready);
    c_underrun: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) o_tx_underrun);
endmodule // voice_frame_monitor

bind voice_frame_serial_master voice_frame_monitor u_voice_frame_monitor (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_clk_link(i_clk_link),
    .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid), .o_rx_sample(o_rx_sample),
    .i_rx_ready(i_rx_ready), .o_tx_underrun(o_tx_underrun), .o_rx_overrun(o_rx_overrun),
    .o_frame_sync(o_frame_sync), .o_bit_clk(o_bit_clk), .o_data_out(o_data_out)
);

/* test/codec_model.sv */
// Codec on the far side of the voice port.
// Assumes master clock and sync; data in pulled up.
`timescale 1ns/1ps

module codec_model (
    // Master pins
    input  wire logic        i_frame_sync,
    input  wire logic        i_bit_clk,
    input  wire logic        i_data_out,
    output logic             o_data_in,
    // Bench side
    input  wire logic        i_float,
    input  wire logic [15:0] i_word,
    output logic      [15:0] o_got,
    output logic      [31:0] o_got_cnt
);
    logic [6:0]  bit_q = 7'h7F;
    logic        sync_q = 1'b0;
    logic [15:0] sh_q;

    initial begin
        o_data_in = 1'b1;
        o_got_cnt = 32'h0;
    end

    // Bit 0 opens as sync rises
    always @(posedge i_bit_clk) begin
        if (i_frame_sync && !sync_q) bit_q = 7'h00;
        else if (bit_q < 7'h7F) bit_q = bit_q + 7'h01;
        sync_q = i_frame_sync;
        o_data_in <= (bit_q < 7'h10 && !i_float) ? i_word[4'hF - bit_q[3:0]] : 1'b1;
    end

    always @(negedge i_bit_clk) begin
        if (bit_q < 7'h10) sh_q = {sh_q[14:0], i_data_out};
        if (bit_q == 7'h0F) begin
            o_got <= sh_q;
            o_got_cnt <= o_got_cnt + 32'h1;
        end
    end
endmodule // codec_model

/* test/voice_frame_serial_master_tb.sv */
// Bench of the voice port with a codec model on the pins.
// Assumes the default divider: 1536 link cycles of 80 ns a frame.
`timescale 1ns/1ps

module voice_frame_serial_master_tb;
    import voice_frame_pkg::*;

    logic        clk_sys = 1'b0;
    logic        clk_link = 1'b0;
    logic        arst_n = 1'b0;
    logic        tx_valid = 1'b0;
    logic        rx_ready = 1'b1;
    logic        p_float = 1'b0;
    sample_t     tx_sample = 16'h0000;
    sample_t     p_word = 16'hC35A;
    logic        tx_ready, rx_valid, frame_start, tx_underrun, rx_overrun;
    logic        frame_sync, bit_clk, data_out, data_in;
    sample_t     rx_sample, p_got;
    logic [31:0] p_got_cnt;
    int          fail_count = 0;
    int          comparisons = 0;
    int          und_cnt = 0;
    int          ovr_cnt = 0;

    always #50 clk_sys = ~clk_sys;
    always #40 clk_link = ~clk_link;

    voice_frame_serial_master u_voice_frame_serial_master (
        .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_clk_link(clk_link),
        .i_tx_valid(tx_valid), .i_tx_sample(tx_sample), .o_tx_ready(tx_ready),
        .o_rx_valid(rx_valid), .o_rx_sample(rx_sample), .i_rx_ready(rx_ready),
        .o_frame_start(frame_start), .o_tx_underrun(tx_underrun), .o_rx_overrun(rx_overrun),
        .o_frame_sync(frame_sync), .o_bit_clk(bit_clk), .o_data_out(data_out),
        .i_data_in(data_in)
    );

    codec_model u_codec_model (
        .i_frame_sync(frame_sync), .i_bit_clk(bit_clk), .i_data_out(data_out),
        .o_data_in(data_in), .i_float(p_float), .i_word(p_word), .o_got(p_got),
        .o_got_cnt(p_got_cnt)
    );

    always @(negedge clk_sys) begin
        if (tx_underrun === 1'b1) und_cnt++;
        if (rx_overrun === 1'b1) ovr_cnt++;
    end

    task automatic check(input logic ok, input string what);
        comparisons++;
        if (!ok) begin
            fail_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    task automatic wait_frame();
        int n;
        @(negedge clk_sys);
        for (n = 1; frame_start !== 1'b1 && n < 3000; n++) @(negedge clk_sys);
        check(n < 3000, "no frame");
    endtask

    task automatic wait_got();
        logic [31:0] c = p_got_cnt;
        int n;
        for (n = 0; p_got_cnt === c && n < 3000; n++) @(negedge clk_sys);
        check(n < 3000, "no word");
    endtask

    task automatic get_rx(input sample_t exp);
        int n;
        @(negedge clk_sys);
        for (n = 1; rx_valid !== 1'b1 && n < 3000; n++) @(negedge clk_sys);
        check(rx_sample === exp, "rx word");
        @(negedge clk_sys);
    endtask

    // Ready is read before the taking edge
    task automatic push(input sample_t w, output logic ok);
        tx_valid <= 1'b1;
        tx_sample <= w;
        @(negedge clk_sys);
        ok = (tx_ready === 1'b1);
        @(posedge clk_sys);
    endtask

    task automatic t_basic();
        realtime t0;
        logic ok;
        int u;
        wait_frame();
        t0 = $realtime;
        u = und_cnt;
        wait_frame();
        check($realtime - t0 > 122700 && $realtime - t0 < 123000, "period");
        @(posedge clk_sys);
        push(16'h8001, ok);
        tx_valid <= 1'b0;
        wait_got();
        check(p_got === 16'h0000 && und_cnt > u, "idle fill");
        wait_got();
        check(ok && p_got === 16'h8001, "tx word");
        get_rx(16'hC35A);
        $display("done basic");
    endtask

    task automatic t_fill();
        logic ok = 1'b1;
        int n = 0;
        wait_frame();
        @(posedge clk_sys);
        while (ok && n < 6) begin
            push(sample_t'(16'h1234 + n * 16'h1111), ok);
            if (ok) n++;
        end
        tx_valid <= 1'b0;
        check(n >= 2 && n < 6, "no refusal");
        wait_got();
        for (int i = 0; i < n; i++) begin
            wait_got();
            check(p_got === sample_t'(16'h1234 + i * 16'h1111), "tx order");
        end
        $display("done fill");
    endtask

    task automatic t_stall();
        int o;
        int k = 0;
        @(posedge clk_sys);
        p_word <= 16'h5AA5;
        wait_frame();
        o = ovr_cnt;
        @(posedge clk_sys);
        rx_ready <= 1'b0;
        repeat (5) wait_frame();
        check(ovr_cnt > o, "no overrun");
        @(posedge clk_sys);
        rx_ready <= 1'b1;
        repeat (16) begin
            @(negedge clk_sys);
            if (rx_valid === 1'b1) begin
                k++;
                check(rx_sample === 16'h5AA5, "held word");
            end
        end
        check(k == 3, "buffered count");
        $display("done stall");
    endtask

    task automatic t_float();
        @(posedge clk_sys);
        p_float <= 1'b1;
        wait_frame();
        get_rx(16'hFFFF);
        @(posedge clk_sys);
        p_float <= 1'b0;
        $display("done float");
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_basic();
        t_fill();
        t_stall();
        t_float();
        final_report();
    end

    // Run needs about 14 frames
    initial begin
        #6000000;
        fail_count++;
        $display("BAD %0t watchdog", $time);
        final_report();
    end
endmodule // voice_frame_serial_master_tb
